// ===== design/ramp_rate_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Down-counting interval timer for the sweep ramp rate.
module ramp_rate_timer #(
  parameter int RATE_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              enable,
  input  wire logic              loadNow,
  input  wire logic [RATE_W-1:0] rateActive,
  input  wire logic [RATE_W-1:0] rateNew,
  // Result
  output logic                   tick
);

  if (RATE_W < 1 || RATE_W > 32) begin
    $error("ramp_rate_timer: RATE_W out of range");
  end

  logic [RATE_W-1:0] count_q;
  logic [RATE_W-1:0] count_d;
  logic              tick_q;
  logic              tick_d;
  wire               expired = (count_q == '0);

  // The reload on expiry takes the active rate, so a value applied with
  // deferred loading waits for the running interval to finish.
  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (loadNow) begin
      count_d = rateNew;
    end else if (enable) begin
      if (expired) begin
        count_d = rateActive;
        tick_d  = 1'b1;
      end else begin
        count_d = count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// ===== design/synth_power_clock_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Control word one bit 6 set powers down the digital core.
// - Control word one bit 5 set powers down the output converter.
// - Control word one bit 4 set powers down the clock input and stops the core clock.
// - Bit 3 clear defers sweep rate load to timeout; set loads on update.
// - Bit 2 set clears the auxiliary accumulator one cycle per update.
// - Bit 1 set clears the phase accumulator one cycle per update.
// - Bit 0 selects the amplitude function: clear cosine, set sine.
// - Control word two sits at address 0x01 and is two bytes wide.
// - Word two bit 15 is output halving; bits 14:9 are the multiplier factor.
// - Word two bits 7 and 6 select CMOS and crystal reference modes.
// - Word two bit 5 set powers down the clock multiplier.
// - Word two bit 3 set halves the reference before the multiplier.
// - Word two bit 2 selects the oscillator band, high when set.
// - Word two bit 1 clear holds the multiplier logic in reset.
// - Word two bit 0 is a read-only multiplier lock status.
module synth_power_clock_control_regs
  import synth_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port from the serial or parallel front end
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [DATA_W-1:0] regRdData,
  output logic                   regRdValid,
  // Pins
  input  wire logic              ioUpdate,
  input  wire logic              multLockRaw,
  // Power controls
  output logic                   digitalPowerDown,
  output logic                   dacPowerDown,
  output logic                   clockInputPowerDown,
  output logic                   coreClockEnable,
  // Accumulator and output controls
  output logic                   auxAccClear,
  output logic                   phaseAccClear,
  output logic                   sineSelect,
  output logic                   rampTick,
  // Reference multiplier controls
  output logic                   multOutDiv2,
  output logic [5:0]             multFactor,
  output logic                   cmosClockMode,
  output logic                   crystalClockMode,
  output logic                   multPowerDown,
  output logic                   multLoRange,
  output logic                   multInDiv2,
  output logic                   high_band_oscillator_select,
  output logic                   multReset,
  output logic                   multLocked
);

  if (C2_MULT_HI - C2_MULT_LO != 5) begin
    $error("synth_power_clock_control_regs: multiplier field must be six bits");
  end
  if (LOCK_QUAL_CYCLES >= (1 << LOCK_CNT_W)) begin
    $error("synth_power_clock_control_regs: lock counter too narrow");
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------
  logic updSync1_q;
  logic updSync2_q;
  logic updPrev_q;
  logic lockSync1_q;
  logic lockSync2_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      updSync1_q  <= 1'b0;
      updSync2_q  <= 1'b0;
      updPrev_q   <= 1'b0;
      lockSync1_q <= 1'b0;
      lockSync2_q <= 1'b0;
    end else begin
      updSync1_q  <= ioUpdate;
      updSync2_q  <= updSync1_q;
      updPrev_q   <= updSync2_q;
      lockSync1_q <= multLockRaw;
      lockSync2_q <= lockSync1_q;
    end
  end

  // Only the rising edge counts, so a long strobe applies the shadow once.
  wire updatePulse = updSync2_q & ~updPrev_q;

  // ---------------------------------------------------------------------
  // Address decode.
  // ---------------------------------------------------------------------
  wire hitOne;
  wire hitTwo;
  wire hitRate;

  assign hitOne  = (regAddr == ADDR_CW_ONE);
  assign hitTwo  = (regAddr == ADDR_CW_TWO);
  assign hitRate = (regAddr == ADDR_SWEEP_RATE);

  wire wrOne  = regWrEn & hitOne;
  wire wrTwo  = regWrEn & hitTwo;
  wire wrRate = regWrEn & hitRate;

  // ---------------------------------------------------------------------
  // Shadow registers written by the host.
  // ---------------------------------------------------------------------
  logic [CW_ONE_W-1:0]     cwOneShadow_q;
  logic [CW_ONE_W-1:0]     cwOneShadow_d;
  logic [CW_TWO_W-1:0]     cwTwoShadow_q;
  logic [CW_TWO_W-1:0]     cwTwoShadow_d;
  logic [SWEEP_RATE_W-1:0] rateShadow_q;
  logic [SWEEP_RATE_W-1:0] rateShadow_d;

  assign cwOneShadow_d = wrOne ? regWrData : cwOneShadow_q;
  assign cwTwoShadow_d = wrTwo ? regWrData[CW_TWO_W-1:0] : cwTwoShadow_q;
  assign rateShadow_d  = wrRate ? regWrData : rateShadow_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cwOneShadow_q <= CW_ONE_RESET;
      cwTwoShadow_q <= CW_TWO_RESET;
      rateShadow_q  <= SWEEP_RESET;
    end else begin
      cwOneShadow_q <= cwOneShadow_d;
      cwTwoShadow_q <= cwTwoShadow_d;
      rateShadow_q  <= rateShadow_d;
    end
  end

  // ---------------------------------------------------------------------
  // Active registers, copied from the shadows on the update strobe.
  // ---------------------------------------------------------------------
  logic [CW_ONE_W-1:0]     cwOneAct_q;
  logic [CW_ONE_W-1:0]     cwOneAct_d;
  logic [CW_TWO_W-1:0]     cwTwoAct_q;
  logic [CW_TWO_W-1:0]     cwTwoAct_d;
  logic [SWEEP_RATE_W-1:0] rateAct_q;
  logic [SWEEP_RATE_W-1:0] rateAct_d;

  // A write in the strobe cycle is not yet in the shadow, so it waits for
  // the next strobe; the host must finish writing before it strobes.
  // Apply on update
  assign cwOneAct_d = updatePulse ? cwOneShadow_q : cwOneAct_q;
  assign cwTwoAct_d = updatePulse ? cwTwoShadow_q : cwTwoAct_q;
  assign rateAct_d  = updatePulse ? rateShadow_q  : rateAct_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cwOneAct_q <= CW_ONE_RESET;
      cwTwoAct_q <= CW_TWO_RESET;
      rateAct_q  <= SWEEP_RESET;
    end else begin
      cwOneAct_q <= cwOneAct_d;
      cwTwoAct_q <= cwTwoAct_d;
      rateAct_q  <= rateAct_d;
    end
  end

  // ---------------------------------------------------------------------
  // Power and clock controls.
  // ---------------------------------------------------------------------
  // Digital core power-down
  assign digitalPowerDown    = cwOneAct_q[C1_DIGITAL_PD];
  assign dacPowerDown        = cwOneAct_q[C1_DAC_PD];
  assign clockInputPowerDown = cwOneAct_q[C1_CLOCK_PD];
  assign sineSelect          = cwOneAct_q[C1_SINE_SEL];

  // The core clock is gated by the digital or clock-input power-down; the register logic itself
  // stays clocked so that the host can always wake the device again.
  logic coreEn_q;
  wire  coreEn_d;

  assign coreEn_d = ~cwOneAct_d[C1_DIGITAL_PD] & ~cwOneAct_d[C1_CLOCK_PD];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreEn_q <= 1'b0;
    end else begin
      coreEn_q <= coreEn_d;
    end
  end

  assign coreClockEnable = coreEn_q;

  // ---------------------------------------------------------------------
  // Accumulator autoclear pulses.
  // ---------------------------------------------------------------------
  logic auxClr_q;
  logic phaseClr_q;
  wire  auxClr_d;
  wire  phaseClr_d;

  // The autoclear bit applied by this same strobe decides the clear.
  // Auxiliary autoclear
  assign auxClr_d   = updatePulse & cwOneShadow_q[C1_AUX_AUTOCLR];
  assign phaseClr_d = updatePulse & cwOneShadow_q[C1_PHASE_AUTOCLR];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auxClr_q   <= 1'b0;
      phaseClr_q <= 1'b0;
    end else begin
      auxClr_q   <= auxClr_d;
      phaseClr_q <= phaseClr_d;
    end
  end

  assign auxAccClear   = auxClr_q;
  assign phaseAccClear = phaseClr_q;

  // ---------------------------------------------------------------------
  // Ramp rate timer.
  // ---------------------------------------------------------------------
  wire rateLoadNow;

  assign rateLoadNow = updatePulse & cwOneShadow_q[C1_LOAD_RATE];

  ramp_rate_timer #(
    .RATE_W     (RATE_W)
  ) u_rise_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (coreEn_q),
    .loadNow    (rateLoadNow),
    .rateActive (rateAct_q[RATE_RISE_LO +: RATE_W]),
    .rateNew    (rateShadow_q[RATE_RISE_LO +: RATE_W]),
    .tick       (rampTick)
  );

  // ---------------------------------------------------------------------
  // Reference multiplier controls.
  // ---------------------------------------------------------------------
  // Divider and factor
  assign multOutDiv2      = cwTwoAct_q[C2_OUT_DIV2];
  assign multFactor       = cwTwoAct_q[C2_MULT_HI:C2_MULT_LO];
  assign cmosClockMode    = cwTwoAct_q[C2_CMOS_MODE];
  assign crystalClockMode = cwTwoAct_q[C2_CRYSTAL_MODE];
  assign multPowerDown    = cwTwoAct_q[C2_MULT_PD];
  assign multLoRange      = cwTwoAct_q[C2_LO_RANGE];
  assign multInDiv2       = cwTwoAct_q[C2_IN_DIV2];
  assign high_band_oscillator_select = cwTwoAct_q[C2_HIGH_BAND];

  logic multRst_q;
  wire  multRst_d;

  // Reset is held while the run bit is clear or the multiplier is off.
  // Multiplier reset
  assign multRst_d = ~cwTwoAct_d[C2_MULT_RUN] | cwTwoAct_d[C2_MULT_PD];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multRst_q <= 1'b1;
    end else begin
      multRst_q <= multRst_d;
    end
  end

  assign multReset = multRst_q;

  // ---------------------------------------------------------------------
  // Lock status: the raw level must hold steady before it is reported,
  // which filters chatter while the loop is still settling.
  // ---------------------------------------------------------------------
  logic [LOCK_CNT_W-1:0] lockCnt_q;
  logic [LOCK_CNT_W-1:0] lockCnt_d;
  logic                  locked_q;
  logic                  locked_d;
  localparam logic [LOCK_CNT_W-1:0] LOCK_TARGET = LOCK_CNT_W'(LOCK_QUAL_CYCLES);

  always_comb begin
    lockCnt_d = lockCnt_q;
    locked_d  = locked_q;
    if (multRst_q || !lockSync2_q) begin
      lockCnt_d = '0;
      locked_d  = 1'b0;
    end else if (lockCnt_q != LOCK_TARGET) begin
      lockCnt_d = lockCnt_q + 1'b1;
    end else begin
      locked_d  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockCnt_q <= '0;
      locked_q  <= 1'b0;
    end else begin
      lockCnt_q <= lockCnt_d;
      locked_q  <= locked_d;
    end
  end

  assign multLocked = locked_q;

  // ---------------------------------------------------------------------
  // Read port: the host reads back what it wrote, with live lock status.
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] rdMux;
  logic [DATA_W-1:0] rdData_q;
  logic              rdValid_q;

  always_comb begin
    rdMux = '0;
    if (hitOne) begin
      rdMux = cwOneShadow_q;
    end else if (hitTwo) begin
      rdMux[CW_TWO_W-1:0] = cwTwoShadow_q;
      rdMux[C2_LOCK]      = locked_q;
    end else if (hitRate) begin
      rdMux = rateShadow_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q  <= '0;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q  <= regRdEn ? rdMux : rdData_q;
      rdValid_q <= regRdEn;
    end
  end

  assign regRdData  = rdData_q;
  assign regRdValid = rdValid_q;

endmodule
`default_nettype wire

// ===== pkg/synth_ctrl_pkg.sv
package synth_ctrl_pkg;

  // Register port geometry.
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 32;

  // Register addresses.
  localparam logic [4:0]  ADDR_CW_ONE     = 5'h00;
  localparam logic [4:0]  ADDR_CW_TWO     = 5'h01;
  localparam logic [4:0]  ADDR_SWEEP_RATE = 5'h08;

  // Register widths and reset values.
  localparam int          CW_ONE_W        = 32;
  localparam int          CW_TWO_W        = 16;
  localparam int          SWEEP_RATE_W    = 32;
  localparam logic [31:0] CW_ONE_RESET    = 32'h0000_0000;
  localparam logic [15:0] CW_TWO_RESET    = 16'h0000;
  localparam logic [31:0] SWEEP_RESET     = 32'h0000_0000;

  // Control word one fields.
  localparam int          C1_DIGITAL_PD   = 6;
  localparam int          C1_DAC_PD       = 5;
  localparam int          C1_CLOCK_PD     = 4;
  localparam int          C1_LOAD_RATE    = 3;
  localparam int          C1_AUX_AUTOCLR  = 2;
  localparam int          C1_PHASE_AUTOCLR = 1;
  localparam int          C1_SINE_SEL     = 0;

  // Control word two fields.
  localparam int          C2_OUT_DIV2     = 15;
  localparam int          C2_MULT_HI      = 14;
  localparam int          C2_MULT_LO      = 9;
  localparam int          C2_OPEN         = 8;
  localparam int          C2_CMOS_MODE    = 7;
  localparam int          C2_CRYSTAL_MODE = 6;
  localparam int          C2_MULT_PD      = 5;
  localparam int          C2_LO_RANGE     = 4;
  localparam int          C2_IN_DIV2      = 3;
  localparam int          C2_HIGH_BAND    = 2;
  localparam int          C2_MULT_RUN     = 1;
  localparam int          C2_LOCK         = 0;

  // Sweep rate register halves.
  localparam int          RATE_W          = 16;
  localparam int          RATE_RISE_LO    = 0;
  localparam int          RATE_FALL_LO    = 16;

  // Lock qualification: the raw lock level must hold this many cycles.
  localparam int          LOCK_QUAL_CYCLES = 16;
  localparam int          LOCK_CNT_W       = 5;

endpackage

// ===== verification/synth_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module synth_host_model
  import synth_ctrl_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register port
  output logic      [ADDR_W-1:0] regAddr,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regWrEn,
  output logic                   regRdEn,
  input  wire logic [DATA_W-1:0] regRdData,
  input  wire logic              regRdValid,
  // Pins
  output logic                   ioUpdate,
  output logic                   multLockRaw
);
  initial begin
    regAddr = 5'h1f;
    regWrData = 32'ha5a5_5a5a;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    ioUpdate = 1'b0;
    multLockRaw = 1'b0;
  end

  // A released bus shows the inverse of its last value, so stale data never looks valid.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
    v = regRdValid;
  endtask

  task automatic strobe();
    @(posedge clk);
    ioUpdate <= 1'b1;
    @(posedge clk);
    ioUpdate <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic setLock(input logic v);
    @(posedge clk);
    multLockRaw <= v;
  endtask

  function automatic logic [15:0] legalTwo(input logic [15:0] d, input int refKhz);
    logic [15:0] r;
    r = d;
    r[C2_OPEN] = CW_TWO_RESET[C2_OPEN];
    r[C2_LO_RANGE] = (refKhz < 5000);
    return r;
  endfunction
endmodule
`default_nettype wire

// ===== verification/synth_power_clock_control_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module synth_power_clock_control_regs_bench
  import synth_ctrl_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  logic              regWrEn, regRdEn, regRdValid, ioUpdate, multLockRaw;
  logic              digitalPowerDown, dacPowerDown, clockInputPowerDown, coreClockEnable;
  logic              auxAccClear, phaseAccClear, sineSelect, rampTick, multOutDiv2;
  logic [5:0]        multFactor;
  logic              cmosClockMode, crystalClockMode, multPowerDown, multLoRange, multInDiv2;
  logic              high_band_oscillator_select, multReset, multLocked;
  int                mismatches = 0, n_compared = 0, cycles = 0, nAux = 0, nPhase = 0, nTick = 0;
  logic [31:0]       actOne = CW_ONE_RESET;
  logic [15:0]       actTwo = CW_TWO_RESET;
  int                refKhz = 25000;
  wire logic [18:0]  pins = {digitalPowerDown, dacPowerDown, clockInputPowerDown, coreClockEnable, sineSelect,
    multOutDiv2, multFactor, cmosClockMode, crystalClockMode, multPowerDown, multLoRange, multInDiv2,
    high_band_oscillator_select, multReset};

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  synth_power_clock_control_regs synth_power_clock_control_regs_inst (.clk, .rst_n, .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData, .regRdValid, .ioUpdate, .multLockRaw, .digitalPowerDown, .dacPowerDown,
    .clockInputPowerDown, .coreClockEnable, .auxAccClear, .phaseAccClear, .sineSelect, .rampTick, .multOutDiv2,
    .multFactor, .cmosClockMode, .crystalClockMode, .multPowerDown, .multLoRange, .multInDiv2,
    .high_band_oscillator_select, .multReset, .multLocked);
  synth_host_model host (.clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid,
    .ioUpdate, .multLockRaw);

  always @(posedge clk) begin
    cycles++;
    nAux += (auxAccClear === 1'b1);
    nPhase += (phaseAccClear === 1'b1);
    nTick += (rampTick === 1'b1);
    if (cycles == 6000) begin
      mismatches++;
      $display("BAD %0t run did not finish", $time);
      wrap_up();
    end
  end

  function automatic logic [18:0] expPins(input logic [31:0] a, input logic [15:0] b);
    return {a[6], a[5], a[4], !(a[6] || a[4]), a[0], b[15:9], b[7:2], !b[1] || b[5]};
  endfunction

  task automatic tally(input bit ok, input string what);
    n_compared++;
    if (!ok) begin
      mismatches++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, $sformatf("word %h expected %h", got, exp));
  endtask
  task automatic cmpPins(input logic [18:0] got, input logic [18:0] exp);
    tally(got === exp, $sformatf("controls %h expected %h", got, exp));
  endtask
  task automatic cmpCount(input int got, input int exp);
    tally(got == exp, $sformatf("count %0d expected %0d", got, exp));
  endtask

  task automatic readCheck(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    host.rd(a, d, v);
    cmpWord({31'h0, v}, 32'h0000_0001);
    cmpWord(d, exp);
  endtask

  task automatic apply(input logic [31:0] one, input logic [15:0] two);
    logic [15:0] t;
    int          a0;
    int          p0;
    t = host.legalTwo(two, refKhz);
    host.wr(ADDR_CW_ONE, one);
    host.wr(ADDR_CW_TWO, {16'h0000, t});
    @(negedge clk);
    cmpPins(pins, expPins(actOne, actTwo));
    a0 = nAux;
    p0 = nPhase;
    host.strobe();
    actOne = one;
    actTwo = t;
    @(negedge clk);
    cmpPins(pins, expPins(actOne, actTwo));
    cmpCount(nAux - a0, int'(actOne[2]));
    cmpCount(nPhase - p0, int'(actOne[1]));
    readCheck(ADDR_CW_ONE, one);
    readCheck(ADDR_CW_TWO, {16'h0000, t[15:1], 1'b0});
  endtask

  task automatic wrap_up();
    $display("Totals: %0d compared, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] w;
    int          t0;
    rst_n = 1'b0;
    void'($urandom(32'h3da34427));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    cmpPins(pins, expPins(actOne, actTwo));
    readCheck(ADDR_CW_TWO, {16'h0000, CW_TWO_RESET});
    host.wr(5'h03, 32'hffff_ffff);
    readCheck(5'h03, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      apply(32'h0000_0001 << i, 16'h0002);
    end
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      refKhz = (i % 2 == 0) ? 4000 : 25000;
      apply(w, w[31:16]);
    end
    refKhz = 25000;
    $display("test controls done");
    apply(32'h0000_0000, 16'h0002);
    host.setLock(1'b1);
    repeat (30) @(negedge clk);
    cmpWord({31'h0, multLocked}, 32'h0000_0001);
    readCheck(ADDR_CW_TWO, {16'h0000, actTwo[15:1], 1'b1});
    apply(32'h0000_0000, 16'h0022);
    host.setLock(1'b0);
    $display("test lock done");
    host.wr(ADDR_SWEEP_RATE, 32'h0000_00c8);
    apply(32'h0000_0008, 16'h0002);
    host.wr(ADDR_SWEEP_RATE, 32'h0000_0009);
    apply(32'h0000_0000, 16'h0002);
    @(negedge clk);
    t0 = nTick;
    repeat (80) @(negedge clk);
    cmpCount(nTick - t0, 0);
    apply(32'h0000_0008, 16'h0002);
    @(negedge clk);
    t0 = nTick;
    repeat (40) @(negedge clk);
    cmpCount(nTick - t0, 4);
    $display("test ramp done");
    wrap_up();
  end
endmodule

bind synth_power_clock_control_regs synth_regs_checker synth_regs_checker_inst (.clk, .rst_n, .regAddr,
  .regRdEn, .regRdData, .regRdValid, .ioUpdate, .multLockRaw, .digitalPowerDown, .dacPowerDown,
  .clockInputPowerDown, .coreClockEnable, .auxAccClear, .phaseAccClear, .sineSelect, .rampTick,
  .multFactor, .multPowerDown, .multReset, .multLocked);
`default_nettype wire

// ===== verification/synth_regs_checker_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module synth_regs_checker
  import synth_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic              regRdValid,
  // Pins
  input wire logic              ioUpdate,
  input wire logic              multLockRaw,
  // Controls
  input wire logic              digitalPowerDown,
  input wire logic              dacPowerDown,
  input wire logic              clockInputPowerDown,
  input wire logic              coreClockEnable,
  input wire logic              auxAccClear,
  input wire logic              phaseAccClear,
  input wire logic              sineSelect,
  input wire logic              rampTick,
  input wire logic [5:0]        multFactor,
  input wire logic              multPowerDown,
  input wire logic              multReset,
  input wire logic              multLocked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_core_clock_gate: assert property (
    $past(rst_n) |-> coreClockEnable == !(digitalPowerDown || clockInputPowerDown))
    else $error("core clock enable disagrees with power-down levels");
  chk_mult_reset_pd: assert property (
    multPowerDown |-> multReset) else $error("powered-down multiplier not held in reset");
  chk_lock_rise: assert property (
    $rose(multLocked) |-> !multReset && $past(multLockRaw, 16))
    else $error("lock reported without a qualified raw lock");
  chk_lock_fall: assert property (
    $fell(multLockRaw) |-> ##[1:4] !multLocked) else $error("lock status kept after raw lock loss");
  chk_lock_in_reset: assert property (
    multReset |=> !multLocked) else $error("lock shown while multiplier in reset");
  chk_aux_single: assert property (
    auxAccClear |=> !auxAccClear) else $error("auxiliary clear longer than one cycle");
  chk_phase_cause: assert property (
    phaseAccClear |-> $past(ioUpdate, 3) || $past(ioUpdate, 4) || $past(ioUpdate, 5))
    else $error("phase clear without an update strobe");
  chk_hold_no_update: assert property (
    (!ioUpdate) [*6] |=> $stable({digitalPowerDown, dacPowerDown, sineSelect, multFactor, multPowerDown}))
    else $error("active controls changed without an update");
  chk_read_valid: assert property (
    $past(rst_n) |-> regRdValid == $past(regRdEn)) else $error("read valid not one cycle after request");
  chk_unmapped_zero: assert property (
    regRdEn && regAddr == 5'h03 |=> regRdData == 32'h0000_0000) else $error("unmapped read not zero");

  cover property ($rose(multLocked));
  cover property (auxAccClear && phaseAccClear);
  cover property (rampTick);
endmodule
`default_nettype wire
